// ### shared/flash_spm_pkg.sv
// Purpose: shared constants for the flash self-program and read-while-write controller
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   sizes here are defaults only; the module parameters override them
package flash_spm_pkg;

  // register byte offsets
  localparam logic [11:0] CTRL_OFS   = 12'h000;
  localparam logic [11:0] LOCK_OFS   = 12'h004;
  localparam logic [11:0] BOUND_OFS  = 12'h008;
  localparam logic [11:0] TARGET_OFS = 12'h00C;

  // control/status field positions
  localparam int RWW_BUSY_BIT = 0;
  localparam int RWW_CLR_BIT  = 1;
  localparam int OP_BUSY_BIT  = 2;
  localparam int HOLD_BIT     = 3;
  localparam int REFUSED_BIT  = 4;
  localparam int OP_RWW_BIT   = 5;

  // lock field positions: group 0 in [1:0], group 1 in [3:2]
  // within a group bit 0 gates writes, bit 1 gates cross-region reads
  localparam int LOCK_APP_LSB   = 0;
  localparam int LOCK_BOOT_LSB  = 2;
  localparam int LOCK_WR_BIT    = 0;
  localparam int LOCK_RD_BIT    = 1;
  localparam logic [3:0] LOCK_RESET = 4'hF;

  // bound register: boot start in [15:0], no_read_while_write_region start in [31:16]
  localparam int BOUND_NO_READ_WHILE_WRITE_REGION_LSB = 16;

  // default geometry, in words
  localparam int FLASH_ADDR_W   = 14;
  localparam int NO_READ_WHILE_WRITE_REGION_WORDS     = 2048;
  localparam int BOOT_MIN_WORDS = 256;
  localparam int PAGE_WORDS     = 64;

  typedef enum logic [1:0] {
    OP_ERASE   = 2'h0,
    OP_WRITE   = 2'h1,
    OP_LOCKSET = 2'h2
  } spm_op_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_START = 2'h1,
    ST_WAIT  = 2'h3
  } seq_state_t;

endpackage

// ### rtl/flash_self_program_rww_control.sv
// Purpose: flash self-program sequencer with boot/application split and read-while-write control
// Assumes: core inputs synchronous to clk; flash array answers each start with one done pulse
// Notes on behaviour
// - flash splits into application and boot regions at a fuse-set boundary.
// - store-to-program-memory fetched from application region is ignored.
// - only store executed from boot region starts programming, any target.
// - application region protection comes from lock group 0.
// - boot region protection comes from lock group 1, independent of group 0.
// - fixed read-while-write and no-read-while-write regions, independent of fuses.
// - reads from no-read-while-write region continue during read-while-write programming.
// - programming a no-read-while-write page halts the core for the whole operation.
// - read-while-write region never returns valid code during self-programming.
// - whole boot region lies inside no-read-while-write region.
// - busy flag reads one while read-while-write reads are blocked.
// - boot code may erase or rewrite the boot region itself.
// - pages matter only for programming; plain reads ignore page boundaries.
// - target address is captured at operation start; pointer is then free.
// - lock bits programmed by software or programmer, cleared only by chip erase or reset.
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
module flash_self_program_rww_control #(
  parameter int ADDR_W     = flash_spm_pkg::FLASH_ADDR_W,
  parameter int NO_READ_WHILE_WRITE_REGION_SIZE  = flash_spm_pkg::NO_READ_WHILE_WRITE_REGION_WORDS,
  parameter int BOOT_MIN   = flash_spm_pkg::BOOT_MIN_WORDS,
  parameter int PAGE_SIZE  = flash_spm_pkg::PAGE_WORDS
) (
  input  wire logic              clk,
  input  wire logic              reset,
  // apb slave
  input  wire logic [11:0]       paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // configuration fuses and external programmer
  input  wire logic [1:0]        bootSizeFuses,
  input  wire logic              progLockWe,
  input  wire logic [3:0]        progLockData,
  input  wire logic              chipErase,
  // core store requests
  input  wire logic              storeReq,
  input  wire logic [ADDR_W-1:0] storePc,
  input  wire logic [ADDR_W-1:0] storeTarget,
  input  wire logic [1:0]        storeOp,
  input  wire logic [3:0]        storeLockData,
  output logic                   storeAccept,
  output logic                   coreHold,
  // core reads (fetch and table reads)
  input  wire logic              readReq,
  input  wire logic [ADDR_W-1:0] readAddr,
  input  wire logic [ADDR_W-1:0] readPc,
  output logic                   readGrant,
  output logic                   readBlocked,
  // flash array
  output logic                   flashStart,
  output logic      [1:0]        flashOp,
  output logic      [ADDR_W-1:0] flashAddr,
  input  wire logic              flashDone
);

  localparam int FULL_W = ADDR_W + 1;
  localparam logic [FULL_W-1:0] FLASH_END  = FULL_W'(1 << ADDR_W);
  localparam logic [ADDR_W-1:0] NO_READ_WHILE_WRITE_REGION_START = ADDR_W'((1 << ADDR_W) - NO_READ_WHILE_WRITE_REGION_SIZE);
  localparam logic [ADDR_W-1:0] PAGE_MASK  = ~ADDR_W'(PAGE_SIZE - 1);

  flash_spm_pkg::seq_state_t state_ff;
  flash_spm_pkg::seq_state_t nxt_state;

  logic [3:0]        lock_ff;
  logic              rwwBusy_ff;
  logic              hold_ff;
  logic              refused_ff;
  logic              opRww_ff;
  logic [ADDR_W-1:0] target_ff;
  logic [1:0]        op_ff;
  logic [ADDR_W-1:0] bootStart;
  logic              opBusy;
  logic              storeFromBoot;
  logic              storeLockOk;
  logic              storeStart;
  logic              storeRefused;
  logic              storeIsLock;
  logic              apbWrite;
  logic              apbRead;
  logic              addrHit;
  logic              swClearBusy;
  logic [31:0]       nxt_prdata;
  logic [1:0]        storeGroup;
  logic [1:0]        readGroup;
  logic              opLaunch;
  logic              nrwwLaunch;
  logic              readCross;
  logic              ctrlWrite;
  logic              lockWrite;
  logic [3:0]        nxt_lock;

  // boot region size doubles per fuse step below 2'b11
  function automatic logic [ADDR_W-1:0] boot_start(input logic [1:0] fuses);
    logic [FULL_W-1:0] size;
    logic [FULL_W-1:0] start;
    size  = FULL_W'(BOOT_MIN) << (2'h3 - fuses);
    start = FLASH_END - size;
    // never let the boot region leak below the fixed no-read-while-write start
    if (start < {1'b0, NO_READ_WHILE_WRITE_REGION_START}) begin
      start = {1'b0, NO_READ_WHILE_WRITE_REGION_START};
    end
    return start[ADDR_W-1:0];
  endfunction

  function automatic logic in_boot(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] bs);
    return a >= bs;
  endfunction

  function automatic logic in_rww(input logic [ADDR_W-1:0] a);
    return a < NO_READ_WHILE_WRITE_REGION_START;
  endfunction

  // lock group for the region that holds an address
  function automatic logic [1:0] lock_group(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] bs,
                                            input logic [3:0] lk);
    if (in_boot(a, bs)) begin
      return lk[flash_spm_pkg::LOCK_BOOT_LSB +: 2];
    end
    return lk[flash_spm_pkg::LOCK_APP_LSB +: 2];
  endfunction

  assign bootStart = boot_start(bootSizeFuses);

  // store decode

  assign opBusy        = (state_ff != flash_spm_pkg::ST_IDLE);
  assign storeFromBoot = in_boot(storePc, bootStart);
  assign storeIsLock   = (storeOp == flash_spm_pkg::OP_LOCKSET);
  assign storeGroup    = lock_group(storeTarget, bootStart, lock_ff);
  // boot code may target the boot region too; only its own lock group can stop it
  assign storeLockOk   = storeIsLock | storeGroup[flash_spm_pkg::LOCK_WR_BIT];
  assign storeStart    = storeReq & storeFromBoot & ~opBusy & storeLockOk &
                         (storeOp != 2'h3);
  assign storeRefused  = storeReq & ~storeStart;
  assign storeAccept   = storeStart;
  // lock updates never reach the array, so only page operations launch the sequencer
  assign opLaunch      = storeStart & ~storeIsLock;
  // the core stops in the very cycle a store to the region it runs from is taken, a cycle before flashStart
  assign nrwwLaunch    = opLaunch & ~in_rww(storeTarget);

  // the start state keeps flashStart a single-cycle pulse whatever the array does next
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      flash_spm_pkg::ST_IDLE: begin
        if (opLaunch) begin
          nxt_state = flash_spm_pkg::ST_START;
        end
      end
      flash_spm_pkg::ST_START: begin
        nxt_state = flash_spm_pkg::ST_WAIT;
      end
      flash_spm_pkg::ST_WAIT: begin
        if (flashDone) begin
          nxt_state = flash_spm_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state = flash_spm_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= flash_spm_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // operation capture: the pointer is free once the page address is latched
  always_ff @(posedge clk) begin
    if (reset) begin
      target_ff <= '0;
      op_ff     <= flash_spm_pkg::OP_ERASE;
      opRww_ff  <= 1'b0;
    end else if (opLaunch) begin
      target_ff <= storeTarget & PAGE_MASK;
      op_ff     <= storeOp;
      opRww_ff  <= in_rww(storeTarget);
    end
  end

  // flash array command, registered
  always_ff @(posedge clk) begin
    if (reset) begin
      flashStart <= 1'b0;
      flashOp    <= flash_spm_pkg::OP_ERASE;
      flashAddr  <= '0;
    end else begin
      flashStart <= (nxt_state == flash_spm_pkg::ST_START);
      if (nxt_state == flash_spm_pkg::ST_START) begin
        flashOp   <= storeOp;
        flashAddr <= storeTarget & PAGE_MASK;
      end
    end
  end

  // core hold for no-read-while-write pages
  always_ff @(posedge clk) begin
    if (reset) begin
      hold_ff <= 1'b0;
    end else if (nrwwLaunch) begin
      hold_ff <= 1'b1;
    end else if (state_ff == flash_spm_pkg::ST_WAIT && flashDone) begin
      // released by the array alone: page times vary, so no timer could be trusted
      hold_ff <= 1'b0;
    end
  end

  // combinational so the core stalls in the same cycle the store is taken
  assign coreHold = hold_ff | nrwwLaunch;

  // busy flag: set at start of any page operation, cleared by software afterwards
  assign swClearBusy = ctrlWrite & pwdata[flash_spm_pkg::RWW_CLR_BIT] & ~opBusy;

  always_ff @(posedge clk) begin
    if (reset) begin
      rwwBusy_ff <= 1'b0;
    end else if (opLaunch) begin
      // any self-programming blocks that region; set wins over a clear
      rwwBusy_ff <= 1'b1;
    end else if (swClearBusy) begin
      rwwBusy_ff <= 1'b0;
    end
  end

  // refused store, sticky until written one
  always_ff @(posedge clk) begin
    if (reset) begin
      refused_ff <= 1'b0;
    end else if (storeRefused) begin
      refused_ff <= 1'b1;
    end else if (ctrlWrite && pwdata[flash_spm_pkg::REFUSED_BIT]) begin
      refused_ff <= 1'b0;
    end
  end

  // lock bits: programming only drives bits to zero; only chip erase or reset restores ones
  // every source is an AND, so two programmers in one cycle can never raise a bit
  always_comb begin
    nxt_lock = lock_ff;
    if (storeStart && storeIsLock) begin
      nxt_lock = nxt_lock & storeLockData;
    end
    if (progLockWe) begin
      nxt_lock = nxt_lock & progLockData;
    end
    if (lockWrite) begin
      nxt_lock = nxt_lock & pwdata[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      lock_ff <= flash_spm_pkg::LOCK_RESET;
    end else if (chipErase) begin
      lock_ff <= flash_spm_pkg::LOCK_RESET;
    end else begin
      lock_ff <= nxt_lock;
    end
  end

  assign readGroup = lock_group(readAddr, bootStart, lock_ff);
  // a read crossing between the two regions is gated by the lock group of the region read
  assign readCross = in_boot(readPc, bootStart) != in_boot(readAddr, bootStart);

  // read path: no page logic here, any word is read alike
  always_comb begin
    readBlocked = 1'b0;
    if (readReq) begin
      if (in_rww(readAddr) && (opBusy || rwwBusy_ff)) begin
        readBlocked = 1'b1;
      end else if (hold_ff) begin
        readBlocked = 1'b1;
      end else if (readCross && !readGroup[flash_spm_pkg::LOCK_RD_BIT]) begin
        readBlocked = 1'b1;
      end
    end
  end

  // reads from the fixed no-read-while-write region keep flowing during read-while-write programming
  assign readGrant = readReq & ~readBlocked;

  // apb slave: zero wait states
  assign apbWrite = psel & penable & pwrite;
  assign apbRead  = psel & ~penable & ~pwrite;
  // register-specific write strobes, shared by the flag and lock logic
  assign ctrlWrite = apbWrite & (paddr == flash_spm_pkg::CTRL_OFS);
  assign lockWrite = apbWrite & (paddr == flash_spm_pkg::LOCK_OFS);
  assign addrHit  = (paddr == flash_spm_pkg::CTRL_OFS) | (paddr == flash_spm_pkg::LOCK_OFS) |
                    (paddr == flash_spm_pkg::BOUND_OFS) | (paddr == flash_spm_pkg::TARGET_OFS);
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~addrHit;

  always_comb begin
    nxt_prdata = 32'h0000_0000;
    unique case (paddr)
      flash_spm_pkg::CTRL_OFS: begin
        nxt_prdata[flash_spm_pkg::RWW_BUSY_BIT] = rwwBusy_ff;
        nxt_prdata[flash_spm_pkg::OP_BUSY_BIT]  = opBusy;
        nxt_prdata[flash_spm_pkg::HOLD_BIT]     = hold_ff;
        nxt_prdata[flash_spm_pkg::REFUSED_BIT]  = refused_ff;
        nxt_prdata[flash_spm_pkg::OP_RWW_BIT]   = opRww_ff;
      end
      flash_spm_pkg::LOCK_OFS: begin
        nxt_prdata[3:0] = lock_ff;
      end
      flash_spm_pkg::BOUND_OFS: begin
        nxt_prdata[ADDR_W-1:0] = bootStart;
        nxt_prdata[flash_spm_pkg::BOUND_NO_READ_WHILE_WRITE_REGION_LSB +: ADDR_W] = NO_READ_WHILE_WRITE_REGION_START;
      end
      flash_spm_pkg::TARGET_OFS: begin
        nxt_prdata[ADDR_W-1:0] = target_ff;
        nxt_prdata[ADDR_W +: 2] = op_ff;
      end
      default: begin
        nxt_prdata = 32'h0000_0000;
      end
    endcase
  end

  // read data captured in the setup cycle so it stands through the access phase
  always_ff @(posedge clk) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (apbRead) begin
      prdata <= nxt_prdata;
    end
  end

endmodule

// ### verif/flash_rww_checker_assertions.sv
// Purpose: port-level checks of the flash self-program sequencer
// Assumes: geometry handed down through the bind
// Notes: boot start is worked out again from the fuses, no-read-while-write start from the parameters
`timescale 1ns/100ps
module flash_rww_checker #(
  parameter int ADDR_W    = 14,
  parameter int NO_READ_WHILE_WRITE_REGION_SIZE = 2048,
  parameter int BOOT_MIN  = 256,
  parameter int PAGE_SIZE = 64
) (
  input wire logic              clk,
  input wire logic              reset,
  input wire logic [1:0]        bootSizeFuses,
  input wire logic              storeReq,
  input wire logic [ADDR_W-1:0] storePc,
  input wire logic [ADDR_W-1:0] storeTarget,
  input wire logic [1:0]        storeOp,
  input wire logic              storeAccept,
  input wire logic              coreHold,
  input wire logic              readReq,
  input wire logic [ADDR_W-1:0] readAddr,
  input wire logic [ADDR_W-1:0] readPc,
  input wire logic              readGrant,
  input wire logic              readBlocked,
  input wire logic              flashStart,
  input wire logic [1:0]        flashOp,
  input wire logic [ADDR_W-1:0] flashAddr,
  input wire logic              flashDone
);
  localparam int NrwwStart = (1 << ADDR_W) - NO_READ_WHILE_WRITE_REGION_SIZE;
  int bootStart;
  assign bootStart = (1 << ADDR_W) - (BOOT_MIN << (3 - bootSizeFuses));
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  app_store_ign_a: assert property (storeReq && storePc < bootStart |-> !storeAccept)
    else $error("store from application region was taken");
  boot_store_go_a: assert property (storeAccept && storeOp < 2'h2 |=> flashStart && flashOp == $past(storeOp))
    else $error("taken store did not start the array");
  addr_capture_a: assert property (flashStart |-> flashAddr == ($past(storeTarget) & ~ADDR_W'(PAGE_SIZE - 1)))
    else $error("array address not the captured page");
  no_read_while_write_region_hold_a: assert property (storeAccept && storeOp < 2'h2 && storeTarget >= NrwwStart |-> coreHold ##1 coreHold)
    else $error("core not held for no-read-while-write page");
  hold_keep_a: assert property (coreHold && !flashDone |=> coreHold)
    else $error("core hold dropped before array done");
  hold_free_a: assert property (flashDone ##1 !storeAccept |-> !coreHold)
    else $error("core hold kept after array done");
  rww_block_a: assert property (readReq && readAddr < NrwwStart && flashStart |-> readBlocked && !readGrant)
    else $error("read-while-write read served during programming");
  no_read_while_write_region_serve_a: assert property (readReq && readAddr >= bootStart && readPc >= bootStart && !coreHold
    |-> readGrant && !readBlocked)
    else $error("boot read refused while core not held");

  cover property (storeAccept && storeTarget >= NrwwStart);
  cover property (readReq && readBlocked);
  cover property (flashDone);
endmodule

bind flash_self_program_rww_control flash_rww_checker #(.ADDR_W(ADDR_W), .NO_READ_WHILE_WRITE_REGION_SIZE(NO_READ_WHILE_WRITE_REGION_SIZE),
  .BOOT_MIN(BOOT_MIN), .PAGE_SIZE(PAGE_SIZE)) chk (.clk, .reset, .bootSizeFuses, .storeReq, .storePc,
  .storeTarget, .storeOp, .storeAccept, .coreHold, .readReq, .readAddr, .readPc, .readGrant,
  .readBlocked, .flashStart, .flashOp, .flashAddr, .flashDone);

// ### verif/flash_array_model.sv
// Purpose: behavioural flash array answering each start with one done pulse
// Assumes: one operation at a time
// Notes: slow stretches the operation so reads can be probed mid-way
`timescale 1ns/100ps
module flash_array_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic flashStart,
  input wire logic slow,
  output logic     flashDone
);
  logic       busy_ff;
  logic [5:0] waitCnt_ff;
  always_ff @(posedge clk) begin
    if (reset || flashStart) begin
      busy_ff <= flashStart && !reset;
      waitCnt_ff <= slow ? 6'd40 : 6'd0;
      flashDone <= 1'b0;
    end else begin
      busy_ff <= busy_ff && waitCnt_ff != 6'd0;
      waitCnt_ff <= waitCnt_ff - (waitCnt_ff != 6'd0 ? 6'd1 : 6'd0);
      flashDone <= busy_ff && waitCnt_ff == 6'd0;
    end
  end
endmodule

// ### verif/tb.sv
// Purpose: self-checking bench for the flash self-program sequencer
// Assumes: default geometry, no-read-while-write from 14'h3800
// Notes: read data and array address expectations are queued by the drivers and matched by a monitor; accept and probe results are checked in the tasks
`timescale 1ns/100ps
module tb;
  logic        clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, storeAccept, coreHold, readGrant, readBlocked, flashStart, flashDone;
  logic        progLockWe = 1'b0, chipErase = 1'b0, storeReq = 1'b0, readReq = 1'b0, slow = 1'b0;
  logic [1:0]  bootSizeFuses = 2'h3, storeOp = 2'h0, flashOp;
  logic [3:0]  progLockData = 4'hF, storeLockData = 4'hF;
  logic [13:0] storePc = 14'h0, storeTarget = 14'h0, readAddr = 14'h0, readPc = 14'h0, flashAddr, tgt;
  int          err_total = 0, checks_done = 0, seed = 32'hD9217B28;
  logic [31:0] rdQ[$];
  logic [13:0] opQ[$];
  always #4 clk = ~clk;
  flash_self_program_rww_control dut (.clk, .reset, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .bootSizeFuses, .progLockWe, .progLockData, .chipErase, .storeReq, .storePc,
    .storeTarget, .storeOp, .storeLockData, .storeAccept, .coreHold, .readReq, .readAddr, .readPc,
    .readGrant, .readBlocked, .flashStart, .flashOp, .flashAddr, .flashDone);
  flash_array_model model (.clk, .reset, .flashStart, .slow, .flashDone);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks=%0d errors=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // a start nobody asked for meets an unaligned expectation and fails
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) chk(prdata, rdQ.pop_front());
    if (flashStart) chk(32'(flashAddr), 32'(opQ.size() > 0 ? opQ.pop_front() : 14'h3FFF));
    if (psel && penable && pready) chk(32'(pslverr), 32'(!(paddr inside {12'h000, 12'h004, 12'h008, 12'h00C})));
  end
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (!pready && n < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 50) begin
      err_total++;
      conclude();
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    rdQ.push_back(exp);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic store(input logic [13:0] pc, t, input logic [1:0] op, input logic go);
    @(posedge clk);
    storeReq <= 1'b1;
    storePc <= pc;
    storeTarget <= t;
    storeOp <= op;
    if (go && op < 2'h2) opQ.push_back(t & 14'h3FC0);
    @(negedge clk);
    chk(32'(storeAccept), 32'(go));
    @(posedge clk);
    storeReq <= 1'b0;
  endtask
  // readReq stays up between probes so it is never driven twice in one step
  task automatic probe(input logic [13:0] a, pc, input logic blk);
    readReq <= 1'b1;
    readAddr <= a;
    readPc <= pc;
    @(negedge clk);
    chk(32'({readBlocked, readGrant}), 32'({blk, !blk}));
    @(posedge clk);
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (!flashDone && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (n == 200) begin
      err_total++;
      conclude();
    end
  endtask

  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    rd(12'h000, 32'h0);
    rd(12'h004, 32'hF);
    rd(12'h008, 32'h38003F00);
    rd(12'h010, 32'h0);
    $display("reset values done");
    store(14'h0100, 14'h0040, 2'h0, 1'b0);
    rd(12'h000, 32'h10);
    apb(1'b1, 12'h000, 32'h10);
    $display("application store done");
    tgt = 14'($unsigned($random(seed))) % 14'h3800;
    slow <= 1'b1;
    store(14'h3F00 | 14'($unsigned($random(seed)) & 8'hFF), tgt, 2'h0, 1'b1);
    probe(14'h0200, 14'h3F00, 1'b1);
    probe(14'h3F10, 14'h3F00, 1'b0);
    wait_done();
    readReq <= 1'b0;
    rd(12'h00C, {18'h0, tgt & 14'h3FC0});
    rd(12'h000, 32'h21);
    probe(14'h0200, 14'h3F00, 1'b1);
    apb(1'b1, 12'h000, 32'h2);
    rd(12'h000, 32'h20);
    probe(14'h0200, 14'h3F00, 1'b0);
    $display("read-while-write erase done");
    slow <= 1'b0;
    store(14'h3F00, 14'h3F40, 2'h1, 1'b1);
    probe(14'h3F10, 14'h3F00, 1'b1);
    wait_done();
    readReq <= 1'b0;
    rd(12'h000, 32'h01);
    apb(1'b1, 12'h000, 32'h2);
    $display("boot self-write done");
    storeLockData <= 4'hE;
    store(14'h3F00, 14'h0000, 2'h2, 1'b1);
    rd(12'h004, 32'hE);
    store(14'h3F00, 14'h0040, 2'h0, 1'b0);
    store(14'h3F00, 14'h3F80, 2'h0, 1'b1);
    wait_done();
    apb(1'b1, 12'h000, 32'h12);
    rd(12'h000, 32'h0);
    progLockData <= 4'h7;
    progLockWe <= 1'b1;
    @(posedge clk);
    progLockWe <= 1'b0;
    rd(12'h004, 32'h6);
    apb(1'b1, 12'h004, 32'hF);
    rd(12'h004, 32'h6);
    chipErase <= 1'b1;
    @(posedge clk);
    chipErase <= 1'b0;
    rd(12'h004, 32'hF);
    $display("lock groups done");
    bootSizeFuses <= 2'h0;
    rd(12'h008, 32'h38003800);
    store(14'h3800, 14'h0080, 2'h0, 1'b1);
    wait_done();
    $display("boot size fuses done");
    conclude();
  end
endmodule
